// ==== rcm_regs.vh ====
// Constants for the reset configuration and module map block
`ifndef RCM_REGS_VH
`define RCM_REGS_VH
`define RCM_STRAP_BOOT16      0
`define RCM_STRAP_BUSREQ      1
`define RCM_STRAP_FCODE       2
`define RCM_STRAP_ADDR_LO     3
`define RCM_STRAP_ADDR_HI     7
`define RCM_STRAP_DISCRETE_PORT_E       8
`define RCM_STRAP_DISCRETE_PORT_F       9
`define RCM_STRAP_TEST        11
`define RCM_BASE_MM0          12'h7FF
`define RCM_BASE_MM1          12'hFFF
`define RCM_BLOCK_AW          12
`define RCM_ARB_ID_W          4
`define RCM_ARB_ID_SIM_RST    4'hF
`define RCM_ARB_ID_ZERO       4'h0
`define RCM_NUM_CS            12
`endif

// ==== rcm_map_decode.v ====
// Address decode of the module control register block
`timescale 1ns/10ps
`default_nettype none
`include "rcm_regs.vh"
module rcm_map_decode (
  input  wire        base_select,   // Register block base select
  input  wire [23:0] addr,          // Bus address
  input  wire        supervisor,    // Supervisor space access
  input  wire        reserved_hit,  // Address falls in a reserved area
  input  wire        restricted,    // Register restricted to supervisor
  input  wire        access_valid,  // Bus cycle active
  output reg         internal_hit,  // Served inside
  output reg         external_pass, // Passed to the external bus
  output reg         access_denied  // User access refused
);
  wire [11:0] base;
  wire        in_block;
  assign base     = base_select ? `RCM_BASE_MM1 : `RCM_BASE_MM0;
  assign in_block = (addr[23:12] == base);
  always @* begin
    internal_hit  = 1'b0;
    external_pass = 1'b0;
    access_denied = 1'b0;
    if (!access_valid) begin
      external_pass = 1'b0;
    end else if (!in_block) begin
      external_pass = 1'b1;
    end else if (restricted && !supervisor) begin
      access_denied = 1'b1;
    end else if (reserved_hit) begin
      internal_hit  = 1'b1;
    end else begin
      internal_hit  = 1'b1;
    end
  end
endmodule
`default_nettype wire

// ==== rcm_arbiter.v ====
// Serial bitwise contention of interrupt arbitration identities
`timescale 1ns/10ps
`default_nettype none
`include "rcm_regs.vh"
module rcm_arbiter #(
  parameter N = 4,
  parameter W = `RCM_ARB_ID_W
) (
  input  wire         clk,      // System clock
  input  wire         rst,      // Synchronous reset
  input  wire         ce,       // Clock enable
  input  wire         start,    // Acknowledge cycle begins
  input  wire [N-1:0] req,      // Requests at the acknowledged level
  input  wire [N*W-1:0] ids,    // Identity of each contender
  output reg          done,     // Pulse when contention ends
  output reg  [N-1:0] winner,   // One-hot winner
  output reg          spurious  // Winner has identity zero
);
  reg  [N-1:0] alive;
  reg  [W-1:0] bitpos;
  reg          busy;
  reg          seen;
  reg  [N-1:0] drive;
  wire         any_one;
  integer      i;
  always @* begin
    drive = {N{1'b0}};
    for (i = 0; i < N; i = i + 1) begin
      drive[i] = alive[i] & ids[i*W + bitpos];
    end
  end
  assign any_one = |drive;
  always @(posedge clk) begin
    if (rst) begin
      alive    <= {N{1'b0}};
      bitpos   <= {W{1'b0}};
      busy     <= 1'b0;
      done     <= 1'b0;
      winner   <= {N{1'b0}};
      spurious <= 1'b0;
      seen     <= 1'b0;
    end else if (ce) begin
      done <= 1'b0;
      if (start && !busy) begin
        // Runs even for a single request so timing never depends on load
        alive  <= req;
        bitpos <= W[W-1:0] - 1'b1;
        busy   <= 1'b1;
        seen   <= 1'b0;
      end else if (busy) begin
        if (any_one) begin
          alive <= drive;
          seen  <= 1'b1;
        end
        if (bitpos == {W{1'b0}}) begin
          busy     <= 1'b0;
          done     <= 1'b1;
          winner   <= any_one ? drive : alive;
          // Identity zero won only if no bit of it was ever one
          spurious <= ~(seen | any_one);
        end else begin
          bitpos <= bitpos - 1'b1;
        end
      end
    end
  end
endmodule
`default_nettype wire

// ==== rcm_reset_config.v ====
// Reset strap capture, pin ownership and module map of the integration module
`timescale 1ns/10ps
`default_nettype none
`include "rcm_regs.vh"
module rcm_reset_config #(
  parameter NMOD = 4,
  parameter NCS  = `RCM_NUM_CS
) (
  input  wire             clk,             // System clock
  input  wire             rst,             // Synchronous reset, high
  input  wire             ce,              // Clock enable
  input  wire [15:0]      data_in,         // Data bus pins as sampled
  input  wire             clock_source_strap, // Clock mode pin
  input  wire             breakpoint_pin,  // Breakpoint pin
  input  wire             base_select_wr,  // Write strobe for base select
  input  wire             base_select_in,  // New base select value
  input  wire             arb_id_wr,       // Write strobe for own identity
  input  wire [3:0]       arb_id_in,       // New own identity
  input  wire [23:0]      addr,            // Bus address
  input  wire             access_valid,    // Bus cycle active
  input  wire             supervisor,      // Supervisor access
  input  wire             reserved_hit,    // Reserved area addressed
  input  wire             restricted,      // Restricted register addressed
  input  wire             iack,            // Interrupt acknowledge begins
  input  wire [NMOD-1:0]  irq_req,         // Same-level requests, 0 is ours
  input  wire [NMOD*4-1:0] mod_arb_ids,    // Other module identities
  input  wire [NCS-1:0]   cs_assert,       // Chip select assertion requests
  input  wire             cs_port_mode,    // Chip selects as output port
  input  wire [NCS-1:0]   cs_port_data,    // Output port data
  output reg              boot_chip_select_16, // Boot port 16 bits wide
  output reg              busreq_pins,     // CS0-2 are request/grant
  output reg              fcode_pins,      // CS3-5 are function codes
  output reg  [4:0]       addr_ext_en,     // CS6-10 as address 19-23
  output reg              discrete_port_e, // Bus control pins as port E
  output reg              discrete_port_f, // Interrupt pins as port F
  output reg              slave_test_enabled, // Test mode status
  output reg              clk_from_synth,  // System clock from synthesizer
  output reg              bdm_enabled,     // Background debug enabled
  output reg              pwm_out_dir,     // PWM pins outputs
  output reg              periph_pins_in,  // Other module ports inputs
  output reg              serial_rx_func,  // Serial receive kept
  output reg              register_block_base_select, // Block base
  output reg  [3:0]       arbitration_identity, // Own identity
  output reg              internal_hit,    // Internal register access
  output reg              external_pass,   // Access goes external
  output reg              access_denied,   // User access refused
  output reg              arb_done,        // Contention finished pulse
  output reg  [NMOD-1:0]  arb_winner,      // Winning requester
  output reg              arb_spurious,    // Spurious interrupt
  output reg  [NCS-1:0]   cs_out           // Chip select pins, active low
);
  reg  [15:0]       strap;
  reg               strap_clk;
  reg               strap_breakpoint_pin;
  reg               in_reset;
  wire              dec_hit;
  wire              dec_ext;
  wire              dec_deny;
  wire              a_done;
  wire [NMOD-1:0]   a_win;
  wire              a_spur;
  wire [NMOD*4-1:0] ids_all;
  wire [4:0]        addr_run;
  wire [NCS-1:0]    next_cs;
  wire [NCS-1:0]    cs_given;
  genvar            g;

  // Slot 0 carries the integration module identity for external requests
  assign ids_all = {mod_arb_ids[NMOD*4-1:4],
                    arbitration_identity};

  // Each low bit extends conversion only while all lower bits are low too
  assign addr_run[0] = ~strap[`RCM_STRAP_ADDR_LO];
  generate
    for (g = 1; g < 5; g = g + 1) begin : g_addr
      assign addr_run[g] = addr_run[g-1] & ~strap[`RCM_STRAP_ADDR_LO + g];
    end
  endgenerate

  // Chip select pin per channel: port data, or asserted low
  generate
    for (g = 0; g < NCS; g = g + 1) begin : g_cs
      if (g < 3) begin : g_req
        assign cs_given[g] = busreq_pins;
      end else if (g < 6) begin : g_fc
        assign cs_given[g] = fcode_pins;
      end else if (g < 11) begin : g_ad
        assign cs_given[g] = addr_ext_en[g-6];
      end else begin : g_own
        assign cs_given[g] = 1'b0;
      end
      // A pin handed to another function stays high and never selects
      assign next_cs[g] = cs_given[g] |
                          (cs_port_mode ? cs_port_data[g] : ~cs_assert[g]);
    end
  endgenerate

  rcm_map_decode u_dec (
    .base_select   (register_block_base_select),
    .addr          (addr),
    .supervisor    (supervisor),
    .reserved_hit  (reserved_hit),
    .restricted    (restricted),
    .access_valid  (access_valid),
    .internal_hit  (dec_hit),
    .external_pass (dec_ext),
    .access_denied (dec_deny)
  );

  rcm_arbiter #(
    .N (NMOD),
    .W (`RCM_ARB_ID_W)
  ) u_arb (
    .clk      (clk),
    .rst      (rst),
    .ce       (ce),
    .start    (iack),
    .req      (irq_req),
    .ids      (ids_all),
    .done     (a_done),
    .winner   (a_win),
    .spurious (a_spur)
  );

  // Straps are sampled every enabled cycle while reset is high; the last sample holds
  always @(posedge clk) begin
    if (ce) begin
      in_reset <= rst;
      if (rst) begin
        strap      <= data_in;
        strap_clk  <= clock_source_strap;
        strap_breakpoint_pin <= breakpoint_pin;
      end
    end
  end

  // Decoded configuration is loaded at release and frozen after
  always @(posedge clk) begin
    if (rst) begin
      boot_chip_select_16 <= 1'b1;
      busreq_pins         <= 1'b0;
      fcode_pins          <= 1'b0;
      addr_ext_en         <= 5'h00;
      discrete_port_e     <= 1'b0;
      discrete_port_f     <= 1'b0;
      slave_test_enabled  <= 1'b0;
      clk_from_synth      <= 1'b1;
      bdm_enabled         <= 1'b0;
      pwm_out_dir         <= 1'b1;
      periph_pins_in      <= 1'b1;
      serial_rx_func      <= 1'b1;
    end else if (ce && in_reset) begin
      boot_chip_select_16 <= strap[`RCM_STRAP_BOOT16];
      busreq_pins         <= ~strap[`RCM_STRAP_BUSREQ];
      fcode_pins          <= ~strap[`RCM_STRAP_FCODE];
      addr_ext_en         <= addr_run;
      discrete_port_e     <= ~strap[`RCM_STRAP_DISCRETE_PORT_E];
      discrete_port_f     <= ~strap[`RCM_STRAP_DISCRETE_PORT_F];
      // Status reads the raw level, so low means test mode enabled
      slave_test_enabled  <= strap[`RCM_STRAP_TEST];
      clk_from_synth      <= strap_clk;
      bdm_enabled         <= ~strap_breakpoint_pin;
      pwm_out_dir         <= 1'b1;
      periph_pins_in      <= 1'b1;
      serial_rx_func      <= 1'b1;
    end
    // Nothing above changes again until the next reset
  end

  always @(posedge clk) begin
    if (rst) begin
      register_block_base_select <= 1'b0;
      arbitration_identity       <= `RCM_ARB_ID_SIM_RST;
      internal_hit               <= 1'b0;
      external_pass              <= 1'b0;
      access_denied              <= 1'b0;
      arb_done                   <= 1'b0;
      arb_winner                 <= {NMOD{1'b0}};
      arb_spurious               <= 1'b0;
      cs_out                     <= {NCS{1'b1}};
    end else if (ce) begin
      if (base_select_wr) begin
        register_block_base_select <= base_select_in;
      end
      if (arb_id_wr) begin
        arbitration_identity <= arb_id_in;
      end
      internal_hit  <= dec_hit;
      external_pass <= dec_ext;
      access_denied <= dec_deny;
      arb_done      <= a_done;
      arb_winner    <= a_win;
      arb_spurious  <= a_done & a_spur;
      cs_out        <= next_cs;
    end
  end
endmodule
`default_nettype wire

// ==== rcm_bus_side.sv ====
// Far-side model of the data bus pins around reset
`timescale 1ns/10ps
`default_nettype none
module rcm_bus_side (
  input  wire logic        clk,   // System clock
  input  wire logic        rst,   // System reset
  input  wire logic [15:0] strap, // Levels to hold during reset
  output wire logic [15:0] data   // Data bus pins
);
  logic [15:0] junk = 16'h0000;
  // After release the bus alternates between the straps and their inverse,
  // so a latch that keeps sampling cannot hide
  always @(negedge clk) begin
    junk <= rst ? ~strap : ~junk;
  end
  assign data = rst ? strap : junk;
endmodule
`default_nettype wire

// ==== rcm_monitor.sv ====
// Assertion checker for the reset configuration block
`timescale 1ns/10ps
`default_nettype none
`include "rcm_regs.vh"
module rcm_monitor #(
  parameter NMOD = 4
) (
  input wire logic            clk,          // Clock
  input wire logic            rst,          // Reset
  input wire logic [15:0]     data_in,      // Data bus
  input wire logic [23:0]     addr,         // Address
  input wire logic            access_valid, // Cycle active
  input wire logic            supervisor,   // Supervisor
  input wire logic            restricted,   // Restricted
  input wire logic            iack,         // Acknowledge
  input wire logic [NMOD-1:0] irq_req,      // Requests
  input wire logic            boot_chip_select_16,        // Boot width
  input wire logic            discrete_port_e,            // Port E
  input wire logic            slave_test_enabled,         // Test status
  input wire logic            register_block_base_select, // Base
  input wire logic [3:0]      arbitration_identity,       // Identity
  input wire logic            internal_hit,  // Internal
  input wire logic            external_pass, // External
  input wire logic            access_denied, // Denied
  input wire logic            arb_done,      // Done
  input wire logic [NMOD-1:0] arb_winner,    // Winner
  input wire logic            arb_spurious,  // Spurious
  input wire logic            busreq_pins,   // Request pins handed over
  input wire logic [11:0]     cs_out         // Chip select pins
);
  default clocking @(posedge clk); endclocking
  wire in_blk = addr[23:12] == {register_block_base_select, 11'h7FF};
  wire deny = restricted && !supervisor;
  strap_capture_a: assert property ($fell(rst) |=>
    slave_test_enabled == $past(data_in[11], 2) &&
    boot_chip_select_16 == $past(data_in[0], 2) &&
    discrete_port_e != $past(data_in[8], 2)) else $error("strap capture");
  reset_default_a: assert property (rst |=>
    arbitration_identity == `RCM_ARB_ID_SIM_RST &&
    !register_block_base_select) else $error("reset defaults");
  strap_hold_a: assert property (disable iff (rst)
    !$past(rst) && !$past(rst, 2) |-> $stable(slave_test_enabled) &&
    $stable(boot_chip_select_16) && $stable(discrete_port_e))
    else $error("strap not held");
  ext_pass_a: assert property (disable iff (rst)
    access_valid && !in_blk |=> external_pass && !internal_hit)
    else $error("outside access not passed");
  int_hit_a: assert property (disable iff (rst)
    access_valid && in_blk && !deny |=> internal_hit && !external_pass)
    else $error("block access not internal");
  user_deny_a: assert property (disable iff (rst)
    access_valid && in_blk && deny |=> access_denied && !external_pass)
    else $error("user access not denied");
  idle_decode_a: assert property (disable iff (rst)
    !access_valid |=> !(internal_hit || external_pass || access_denied))
    else $error("decode without access");
  arb_latency_a: assert property (disable iff (rst)
    arb_done |-> $past(iack, 6)) else $error("contention latency");
  arb_pulse_a: assert property (disable iff (rst)
    arb_done || arb_spurious |-> arb_done ##1 !arb_done)
    else $error("done pulse");
  arb_winner_a: assert property (disable iff (rst)
    arb_done && !arb_spurious |-> $onehot(arb_winner) &&
    (arb_winner & $past(irq_req, 6)) != 0) else $error("bad winner");
  cs_handover_a: assert property (disable iff (rst)
    busreq_pins |=> &cs_out[2:0]) else $error("chip select on request pin");
endmodule
bind rcm_reset_config rcm_monitor #(.NMOD(NMOD)) u_rcm_monitor (
  .clk, .rst, .data_in, .addr, .access_valid, .supervisor, .restricted,
  .iack, .irq_req, .boot_chip_select_16, .discrete_port_e,
  .slave_test_enabled, .register_block_base_select, .arbitration_identity,
  .internal_hit, .external_pass, .access_denied, .arb_done, .arb_winner,
  .arb_spurious, .busreq_pins, .cs_out);
`default_nettype wire

// ==== tb.sv ====
// Self-checking bench for the reset configuration block
`timescale 1ns/10ps
`default_nettype none
module tb;
  logic clk = 0, rst = 1, ce = 1, clock_source_strap = 1, breakpoint_pin = 1;
  logic base_select_wr = 0, base_select_in = 0, arb_id_wr = 0;
  logic access_valid = 0, supervisor = 0, reserved_hit = 0, restricted = 0;
  logic iack = 0, cs_port_mode = 0;
  logic [3:0]  arb_id_in = 4'h0, irq_req = 4'h0, arbitration_identity;
  logic [23:0] addr = 24'h000000;
  logic [15:0] strap = 16'hFFFF, data_in, mod_arb_ids = 16'h0A50;
  logic [11:0] cs_assert = 12'h000, cs_port_data = 12'h000, cs_out;
  logic [4:0]  addr_ext_en;
  logic [3:0]  arb_winner;
  logic boot_chip_select_16, busreq_pins, fcode_pins, discrete_port_e;
  logic discrete_port_f, slave_test_enabled, clk_from_synth, bdm_enabled;
  logic pwm_out_dir, periph_pins_in, serial_rx_func, internal_hit;
  logic register_block_base_select, external_pass, access_denied;
  logic arb_done, arb_spurious;
  int   mismatches = 0, n_compared = 0, cycles = 0;
  rcm_bus_side u_rcm_bus_side (.clk, .rst, .strap, .data(data_in));
  rcm_reset_config u_rcm_reset_config (.clk, .rst, .ce, .data_in,
    .clock_source_strap, .breakpoint_pin, .base_select_wr, .base_select_in,
    .arb_id_wr, .arb_id_in, .addr, .access_valid, .supervisor,
    .reserved_hit, .restricted, .iack, .irq_req, .mod_arb_ids, .cs_assert,
    .cs_port_mode, .cs_port_data, .boot_chip_select_16, .busreq_pins,
    .fcode_pins, .addr_ext_en, .discrete_port_e, .discrete_port_f,
    .slave_test_enabled, .clk_from_synth, .bdm_enabled, .pwm_out_dir,
    .periph_pins_in, .serial_rx_func, .register_block_base_select,
    .arbitration_identity, .internal_hit, .external_pass, .access_denied,
    .arb_done, .arb_winner, .arb_spurious, .cs_out);
  always #2 clk = ~clk;
  always @(posedge clk) begin
    cycles++;
    if (cycles == 3000) begin
      mismatches++;
      results();
    end
  end
  task chk(input string what, input logic [15:0] exp, got);
    n_compared++;
    if (exp !== got) begin
      mismatches++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask
  task t_straps(input logic [15:0] s, input logic cm);
    logic [4:0] ae;
    ae[0] = !s[3];
    for (int k = 1; k < 5; k++) ae[k] = ae[k-1] & !s[3+k];
    @(negedge clk);
    strap = s;
    clock_source_strap = cm;
    breakpoint_pin = !cm;
    rst = 1;
    repeat (5) @(negedge clk);
    rst = 0;
    // Bus keeps toggling meanwhile, the outputs must not follow it
    repeat (4) @(negedge clk);
    chk("boot16", s[0], boot_chip_select_16);
    chk("busreq", !s[1], busreq_pins);
    chk("fcode", !s[2], fcode_pins);
    chk("addr_ext", ae, addr_ext_en);
    chk("port_e", !s[8], discrete_port_e);
    chk("port_f", !s[9], discrete_port_f);
    chk("slave", s[11], slave_test_enabled);
    chk("clk_src", cm, clk_from_synth);
    chk("bdm", cm, bdm_enabled);
    chk("dir", 3'h7, {pwm_out_dir, periph_pins_in, serial_rx_func});
    chk("arb_id", 4'hF, arbitration_identity);
    $display("straps %h done", s);
  endtask
  task acc(input logic [23:0] a, input logic [3:0] vsrx,
           input logic [2:0] exp);
    {access_valid, supervisor, restricted, reserved_hit} = vsrx;
    addr = a;
    @(negedge clk);
    chk("decode", exp, {internal_hit, external_pass, access_denied});
    access_valid = 0;
    @(negedge clk);
    chk("idle", 3'h0, {internal_hit, external_pass, access_denied});
  endtask
  task t_map(input logic sel);
    logic [11:0] b;
    b = {sel, 11'h7FF};
    base_select_in = sel;
    base_select_wr = 1;
    @(negedge clk) base_select_wr = 0;
    chk("base", sel, register_block_base_select);
    acc({b, 12'h000}, 4'hC, 3'h4);
    acc({b, 12'h000} - 24'h1, 4'hC, 3'h2);
    acc({b ^ 12'h800, 12'hFFF}, 4'hC, 3'h2);
    acc({b, 12'hFFF}, 4'hA, 3'h1);
    acc({b, 12'h020}, 4'hE, 3'h4);
    acc({b, 12'h030}, 4'hD, 3'h4);
    acc({b, 12'h040}, 4'h4, 3'h0);
    $display("map %0d done", sel);
  endtask
  task t_arb(input logic [3:0] req, w, input logic sp);
    irq_req = req;
    iack = 1;
    @(negedge clk) iack = 0;
    repeat (4) @(negedge clk);
    chk("early", 1'b0, arb_done);
    @(negedge clk);
    chk("done", 1'b1, arb_done);
    chk("spurious", sp, arb_spurious);
    if (!sp) chk("winner", w, arb_winner);
    $display("arb %b done", req);
  endtask
  task results;
    $display("compared %0d mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  initial begin
    t_straps(16'hFFFF, 1'b1);
    t_straps(16'hF5E6, 1'b1);
    t_straps(16'h0000, 1'b0);
    t_map(1'b0);
    t_map(1'b1);
    t_arb(4'b0110, 4'b0100, 1'b0);
    t_arb(4'b0111, 4'b0001, 1'b0);
    t_arb(4'b0010, 4'b0010, 1'b0);
    t_arb(4'b1000, 4'b0000, 1'b1);
    arb_id_wr = 1;
    @(negedge clk) arb_id_wr = 0;
    t_arb(4'b0001, 4'b0000, 1'b1);
    t_arb(4'b0011, 4'b0010, 1'b0);
    // Straps of all zeros handed chip selects 0 to 10 to other functions
    cs_assert = 12'hFFF;
    @(negedge clk);
    @(negedge clk);
    chk("cs_given", 12'h7FF, cs_out);
    t_straps(16'hFFFF, 1'b1);
    cs_assert = 12'h801;
    @(negedge clk);
    @(negedge clk);
    chk("cs", 12'h7FE, cs_out);
    cs_port_mode = 1;
    cs_port_data = 12'hA5C;
    @(negedge clk);
    @(negedge clk);
    chk("cs_port", 12'hA5C, cs_out);
    ce = 0;
    cs_port_data = 12'h3C3;
    @(negedge clk);
    @(negedge clk);
    chk("ce_hold", 12'hA5C, cs_out);
    ce = 1;
    @(negedge clk);
    @(negedge clk);
    chk("ce_run", 12'h3C3, cs_out);
    $display("chip select done");
    results();
  end
endmodule
`default_nettype wire
